// ===== core/bil_loader.sv
// boot image loader for one tile: reset sequence, source pick, image copy, crc check, pll
// assumes a byte source with valid/ready and a ram write port that never stalls
// Functional notes
// - while reset pin is low, pins are pulled down and execution does not start.
// - after reset release, wait 15 to 150 us before booting.
// - security bit 5 set selects otp boot, otherwise embedded flash.
// - image starts with a 32-bit word count, then that many program words.
// - word after program is crc; skip sentinel disables the check.
// - length and crc words are least significant byte first.
// - program copied to lowest ram address, execution starts there.
// - crc covers the length word and all program bytes, not the crc word.
// - crc uses the reflected ethernet polynomial.
// - crc preset all ones, residue inverted before compare.
// - boot pll setting is output divider 1, feedback 63, reference divider 0.
// - tile clock is osc times (f+1)/2 over (r+1) over (od+1).
// - pll fields change by a write to the pll configuration register.
// - secure boot starts from otp address zero, bypassing the boot rom.
`default_nettype none
module bil_loader #(
  parameter int unsigned SEQ_CYCLES = bil_pkg::SEQ_MIN_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // pins
  input wire logic rst_pin_n,
  output logic gpio_pull_down,
  // security register from otp
  input wire logic [31:0] security_reg,
  // boot byte stream from the selected source
  input wire logic [7:0] src_byte,
  input wire logic src_valid,
  output logic src_ready,
  output logic src_start,
  output bil_pkg::bil_src_t src_sel,
  output logic [31:0] src_addr,
  // ram write
  output bil_pkg::bil_ram_wr_t ram_wr,
  // execution control
  output logic exec_start,
  output logic [31:0] exec_addr,
  output logic boot_fail,
  // pll setting
  output bil_pkg::bil_pll_t pll_cfg,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata
);
  initial begin
    if (SEQ_CYCLES < bil_pkg::SEQ_MIN_CYC || SEQ_CYCLES > bil_pkg::SEQ_MAX_CYC) begin
      $error("SEQ_CYCLES outside the reset sequence window");
    end
  end

  typedef enum logic [2:0] {
    ST_RESET, ST_SEQ, ST_LEN, ST_PROG, ST_CRC, ST_RUN, ST_FAIL
  } bil_state_t;

  // three-flop sync of the reset pin; change counts when stages 2 and 3 agree
  logic [2:0] rst_sync_q;
  logic rst_rel_q;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rst_sync_q <= 3'h0;
      rst_rel_q <= 1'b0;
    end else begin
      rst_sync_q <= {rst_sync_q[1:0], rst_pin_n};
      if (rst_sync_q[2] == rst_sync_q[1]) begin
        rst_rel_q <= rst_sync_q[2];
      end
    end
  end

  bil_state_t state_q;
  logic [$clog2(bil_pkg::SEQ_MAX_CYC+1)-1:0] seq_cnt_q;
  logic [1:0] byte_idx_q;
  logic [31:0] word_q, len_q, words_left_q, crc_stored_q, crc_q, wr_addr_q;
  logic crc_ok_q;

  // one byte through the reflected crc, lsb first
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ bil_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  logic take;
  logic [31:0] word_d;
  logic [31:0] crc_final;
  always_comb begin
    take = src_valid && src_ready;
    // bytes enter at the top and shift down: first byte ends least significant
    word_d = {src_byte, word_q[31:8]};
    crc_final = ~crc_q;
  end

  logic secure;
  assign secure = security_reg[bil_pkg::SEC_BOOT_BIT];

  always_ff @(posedge clk_sys) begin
    if (srst || !rst_rel_q) begin
      state_q <= ST_RESET;
      seq_cnt_q <= '0;
    end else begin
      unique case (state_q)
        ST_RESET: begin
          state_q <= ST_SEQ;
          seq_cnt_q <= '0;
        end
        ST_SEQ: begin
          seq_cnt_q <= seq_cnt_q + 1'b1;
          if (32'(seq_cnt_q) + 32'd1 >= SEQ_CYCLES) begin
            state_q <= ST_LEN;
          end
        end
        ST_LEN: begin
          if (take && byte_idx_q == 2'h3) begin
            state_q <= (word_d == 32'h0) ? ST_CRC : ST_PROG;
          end
        end
        ST_PROG: begin
          if (take && byte_idx_q == 2'h3 && words_left_q == 32'h1) begin
            state_q <= ST_CRC;
          end
        end
        ST_CRC: begin
          if (take && byte_idx_q == 2'h3) begin
            if (word_d == bil_pkg::CRC_SKIP || word_d == crc_final) begin
              state_q <= ST_RUN;
            end else begin
              state_q <= ST_FAIL;
            end
          end
        end
        ST_RUN: state_q <= ST_RUN;
        ST_FAIL: state_q <= ST_FAIL;
      endcase
    end
  end

  // byte assembly, counts and crc
  always_ff @(posedge clk_sys) begin
    if (srst || state_q == ST_RESET || state_q == ST_SEQ) begin
      byte_idx_q <= 2'h0;
      word_q <= 32'h0;
      len_q <= 32'h0;
      words_left_q <= 32'h0;
      crc_stored_q <= 32'h0;
      crc_q <= bil_pkg::CRC_INIT;
      wr_addr_q <= bil_pkg::RAM_BASE;
    end else if (take) begin
      byte_idx_q <= byte_idx_q + 2'h1;
      word_q <= word_d;
      if (state_q != ST_CRC) begin
        crc_q <= crc_byte(crc_q, src_byte);
      end
      if (byte_idx_q == 2'h3) begin
        if (state_q == ST_LEN) begin
          len_q <= word_d;
          words_left_q <= word_d;
        end else if (state_q == ST_PROG) begin
          words_left_q <= words_left_q - 32'h1;
          wr_addr_q <= wr_addr_q + 32'h4;
        end else begin
          crc_stored_q <= word_d;
        end
      end
    end
  end

  // ram write, source handshake, execution outputs
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ram_wr <= '0;
      src_ready <= 1'b0;
      src_start <= 1'b0;
      src_sel <= bil_pkg::BIL_SRC_NONE;
      src_addr <= 32'h0;
      exec_start <= 1'b0;
      exec_addr <= 32'h0;
      boot_fail <= 1'b0;
      crc_ok_q <= 1'b0;
      gpio_pull_down <= 1'b1;
    end else begin
      gpio_pull_down <= !rst_rel_q;
      ram_wr.we <= take && state_q == ST_PROG && byte_idx_q == 2'h3;
      ram_wr.addr <= wr_addr_q;
      ram_wr.data <= word_d;
      src_start <= (state_q == ST_SEQ) && (32'(seq_cnt_q) + 32'd1 >= SEQ_CYCLES);
      if (state_q == ST_SEQ) begin
        src_sel <= secure ? bil_pkg::BIL_SRC_OTP : bil_pkg::BIL_SRC_FLASH;
        src_addr <= bil_pkg::OTP_BASE;
      end
      src_ready <= rst_rel_q && (state_q == ST_LEN || state_q == ST_PROG || state_q == ST_CRC)
                   && !(take && byte_idx_q == 2'h3 && (state_q == ST_CRC ||
                        (state_q == ST_PROG && words_left_q == 32'h1)));
      exec_start <= rst_rel_q && state_q == ST_RUN;
      exec_addr <= bil_pkg::RAM_BASE;
      boot_fail <= rst_rel_q && state_q == ST_FAIL;
      if (state_q == ST_CRC && take && byte_idx_q == 2'h3) begin
        crc_ok_q <= word_d == crc_final;
      end
    end
  end

  // pll configuration register; boot value restored by reset
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pll_cfg <= '{output_divider: bil_pkg::PLL_OD_BOOT, feedback: bil_pkg::PLL_F_BOOT,
                   ref_div: bil_pkg::PLL_R_BOOT};
    end else if (reg_we && reg_addr == bil_pkg::REG_PLL_CFG) begin
      // range limits and vco window are left to software
      pll_cfg.ref_div <= reg_wdata[bil_pkg::PLL_R_LSB +: 6];
      pll_cfg.feedback <= reg_wdata[bil_pkg::PLL_F_LSB +: 12];
      pll_cfg.output_divider <= reg_wdata[bil_pkg::PLL_OD_LSB +: 3];
    end
  end
  // tile clock follows osc*(f+1)/2/(r+1)/(od+1) in the analog pll itself

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata <= 32'h0;
    end else if (reg_re) begin
      unique case (reg_addr)
        bil_pkg::REG_PLL_CFG: begin
          reg_rdata <= 32'h0;
          reg_rdata[bil_pkg::PLL_R_LSB +: 6] <= pll_cfg.ref_div;
          reg_rdata[bil_pkg::PLL_F_LSB +: 12] <= pll_cfg.feedback;
          reg_rdata[bil_pkg::PLL_OD_LSB +: 3] <= pll_cfg.output_divider;
        end
        bil_pkg::REG_STATUS: reg_rdata <= {24'h0, 1'b0, crc_ok_q, 3'(state_q),
                                           secure, boot_fail, exec_start};
        bil_pkg::REG_LENGTH: reg_rdata <= len_q;
        bil_pkg::REG_CRC: reg_rdata <= crc_stored_q;
        default: reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  chk_reset_no_exec: assert property (@(posedge clk_sys) disable iff (srst)
    !rst_rel_q |=> !exec_start && gpio_pull_down) else $error("ran in reset");
  chk_seq_min_wait: assert property (@(posedge clk_sys) disable iff (srst)
    $rose(rst_rel_q) |=> !src_ready [*8]) else $error("boot too early");
  chk_src_pick: assert property (@(posedge clk_sys) disable iff (srst)
    src_start |-> src_sel == (secure ? bil_pkg::BIL_SRC_OTP : bil_pkg::BIL_SRC_FLASH))
    else $error("wrong boot source");
  chk_ram_base: assert property (@(posedge clk_sys) disable iff (srst)
    $rose(state_q == ST_PROG) |-> wr_addr_q == bil_pkg::RAM_BASE)
    else $error("copy not at ram base");
  chk_exec_addr: assert property (@(posedge clk_sys) disable iff (srst)
    exec_start |-> exec_addr == bil_pkg::RAM_BASE) else $error("bad entry");
  chk_fail_halt: assert property (@(posedge clk_sys) disable iff (srst)
    boot_fail |-> !exec_start ##1 (!exec_start || !rst_rel_q)) else $error("ran on fail");
  chk_crc_skip: assert property (@(posedge clk_sys) disable iff (srst)
    state_q == ST_CRC && take && byte_idx_q == 2'h3 && word_d == bil_pkg::CRC_SKIP
    |=> state_q == ST_RUN) else $error("skip ignored");
  chk_pll_write: assert property (@(posedge clk_sys) disable iff (srst)
    reg_we && reg_addr == bil_pkg::REG_PLL_CFG |=>
    pll_cfg.feedback == $past(reg_wdata[19:8])) else $error("pll write lost");

  // cycles since the synchronised pin release, saturating
  // only the wait checks read it, so it costs nothing in the boot path
  logic [$clog2(bil_pkg::SEQ_MAX_CYC+8)-1:0] rel_cnt_q;
  always_ff @(posedge clk_sys) begin
    if (srst || !rst_rel_q) begin
      rel_cnt_q <= '0;
    end else if (rel_cnt_q != '1) begin
      rel_cnt_q <= rel_cnt_q + 1'b1;
    end
  end

  // the start pulse lands one cycle after the counted wait
  chk_seq_window: assert property (@(posedge clk_sys) disable iff (srst)
    src_start |-> 32'(rel_cnt_q) >= SEQ_CYCLES && 32'(rel_cnt_q) <= SEQ_CYCLES + 32'd2)
    else $error("boot start outside wait window");

  chk_ready_in_reset: assert property (@(posedge clk_sys) disable iff (srst)
    !rst_rel_q |=> !src_ready)
    else $error("byte taken in reset");

  chk_pull_release: assert property (@(posedge clk_sys) disable iff (srst)
    rst_rel_q |=> !gpio_pull_down)
    else $error("pull down kept after release");

  chk_src_addr: assert property (@(posedge clk_sys) disable iff (srst)
    src_start |-> src_addr == bil_pkg::OTP_BASE)
    else $error("source start address");

  chk_len_zero: assert property (@(posedge clk_sys) disable iff (srst)
    rst_rel_q && state_q == ST_LEN && take && byte_idx_q == 2'h3 && word_d == 32'h0
    |=> state_q == ST_CRC)
    else $error("empty image not sent to crc");

  chk_addr_step: assert property (@(posedge clk_sys) disable iff (srst)
    ram_wr.we && rst_rel_q |-> ram_wr.addr == wr_addr_q - 32'h4)
    else $error("ram address step");

  // preset is loaded throughout the wait, so the first byte sees all ones
  chk_crc_preset: assert property (@(posedge clk_sys) disable iff (srst)
    state_q == ST_SEQ |=> crc_q == bil_pkg::CRC_INIT)
    else $error("crc preset");

  chk_crc_match: assert property (@(posedge clk_sys) disable iff (srst)
    rst_rel_q && state_q == ST_CRC && take && byte_idx_q == 2'h3 && word_d == crc_final
    |=> state_q == ST_RUN)
    else $error("good crc refused");

  chk_crc_bad: assert property (@(posedge clk_sys) disable iff (srst)
    rst_rel_q && state_q == ST_CRC && take && byte_idx_q == 2'h3 &&
    word_d != crc_final && word_d != bil_pkg::CRC_SKIP |=> state_q == ST_FAIL)
    else $error("bad crc accepted");

  chk_fail_sticky: assert property (@(posedge clk_sys) disable iff (srst)
    rst_rel_q && state_q == ST_FAIL |=> state_q == ST_FAIL)
    else $error("left failure halt");

  // once the image is done no further byte may be consumed
  chk_done_idle: assert property (@(posedge clk_sys) disable iff (srst)
    (state_q == ST_RUN || state_q == ST_FAIL) |-> !src_ready)
    else $error("byte taken after image");

  chk_pll_hold: assert property (@(posedge clk_sys) disable iff (srst)
    !(reg_we && reg_addr == bil_pkg::REG_PLL_CFG) |=> $stable(pll_cfg))
    else $error("pll changed without write");

  chk_pll_ref: assert property (@(posedge clk_sys) disable iff (srst)
    reg_we && reg_addr == bil_pkg::REG_PLL_CFG |=>
    pll_cfg.ref_div == $past(reg_wdata[5:0]) &&
    pll_cfg.output_divider == $past(reg_wdata[22:20]))
    else $error("pll divider write lost");

  chk_exec_level: assert property (@(posedge clk_sys) disable iff (srst)
    rst_rel_q && state_q == ST_RUN |=> exec_start)
    else $error("run without start");
endmodule
`default_nettype wire

// ===== core/bil_pkg.sv
// boot image loader package: timing, image constants, pll defaults, register map
// assumes a 10 MHz system clock and a byte-wide image source
`default_nettype none
package bil_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned SEQ_MIN_US = 15;
  localparam int unsigned SEQ_MAX_US = 150;
  // least time truncates the clock to whole MHz, at least one cycle
  localparam int unsigned SEQ_MIN_CYC = (SEQ_MIN_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
                                        SEQ_MIN_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SEQ_MAX_CYC = SEQ_MAX_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SEC_BOOT_BIT = 5;
  localparam logic [31:0] CRC_SKIP = 32'h0D15AB1E;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] RAM_BASE = 32'h00000000;
  localparam logic [31:0] OTP_BASE = 32'h00000000;
  localparam logic [2:0] PLL_OD_BOOT = 3'h1;
  localparam logic [11:0] PLL_F_BOOT = 12'h03F;
  localparam logic [5:0] PLL_R_BOOT = 6'h00;
  // register map
  localparam logic [3:0] REG_PLL_CFG = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_LENGTH = 4'h8;
  localparam logic [3:0] REG_CRC = 4'hC;
  localparam int unsigned PLL_R_LSB = 0;
  localparam int unsigned PLL_F_LSB = 8;
  localparam int unsigned PLL_OD_LSB = 20;
  typedef struct packed {
    logic [2:0] output_divider;
    logic [11:0] feedback;
    logic [5:0] ref_div;
  } bil_pll_t;
  typedef struct packed {
    logic we;
    logic [31:0] addr;
    logic [31:0] data;
  } bil_ram_wr_t;
  typedef enum logic [1:0] {
    BIL_SRC_NONE,
    BIL_SRC_OTP,
    BIL_SRC_FLASH
  } bil_src_t;
endpackage
`default_nettype wire

// ===== tb/bil_flash_model.sv
// byte source standing for the boot flash or otp behind the loader
// assumes the bench pushes image bytes into img_q before releasing the reset pin
`default_nettype none
module bil_flash_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // byte stream
  input wire logic src_start,
  input wire logic src_ready,
  output logic [7:0] src_byte,
  output logic src_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] img_q[$];
  logic run_q = 1'b0;
  initial begin
    src_byte = 8'h00;
    src_valid = 1'b0;
  end
  // bytes leave in push order, so the bench decides byte order
  always @(posedge clk_sys) begin
    if (src_valid && src_ready) begin
      void'(img_q.pop_front());
    end
    // an offered byte is held until taken; idle data toggles so stale values never match
    if (!(src_valid && !src_ready)) begin
      if (run_q && img_q.size() > 0 && $urandom_range(3) != 0) begin
        src_valid <= 1'b1;
        src_byte <= img_q[0];
      end else begin
        src_valid <= 1'b0;
        src_byte <= ~src_byte;
      end
    end
    run_q <= !srst && (run_q || src_start);
  end
endmodule
`default_nettype wire

// ===== tb/bil_loader_tb.sv
// bench for the loader: builds images, boots them, compares ram writes and status
// assumes bil_pkg, bil_loader and bil_flash_model are compiled first
`default_nettype none
module bil_loader_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic rst_pin_n = 1'b0;
  logic [31:0] security_reg = 32'h0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [7:0] src_byte;
  logic src_valid, src_ready, src_start, gpio_pull_down, exec_start, boot_fail;
  bil_pkg::bil_src_t src_sel;
  logic [31:0] src_addr, exec_addr, reg_rdata, rd, v;
  bil_pkg::bil_ram_wr_t ram_wr;
  bil_pkg::bil_pll_t pll_cfg;
  logic [31:0] exp_q[$];
  logic [31:0] got_q[$];
  logic [31:0] adr_q[$];
  int mismatches = 0;
  int cmp_count = 0;
  always #50 clk_sys = ~clk_sys;
  bil_loader bil_loader_i (.clk_sys(clk_sys), .srst(srst), .rst_pin_n(rst_pin_n),
    .gpio_pull_down(gpio_pull_down), .security_reg(security_reg), .src_byte(src_byte),
    .src_valid(src_valid), .src_ready(src_ready), .src_start(src_start), .src_sel(src_sel),
    .src_addr(src_addr), .ram_wr(ram_wr), .exec_start(exec_start), .exec_addr(exec_addr),
    .boot_fail(boot_fail), .pll_cfg(pll_cfg), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata));
  bil_flash_model bil_flash_model_i (.clk_sys(clk_sys), .srst(srst), .src_start(src_start),
    .src_ready(src_ready), .src_byte(src_byte), .src_valid(src_valid));
  always @(posedge clk_sys) begin
    if (ram_wr.we === 1'b1) begin
      got_q.push_back(ram_wr.data);
      adr_q.push_back(ram_wr.addr);
    end
  end
  // inputs change 1 ns after the edge, outputs are settled there too
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    tick();
    reg_we <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_re <= 1'b1;
    tick();
    reg_re <= 1'b0;
    d = reg_rdata;
  endtask
  function automatic logic [31:0] crc_of(input logic [7:0] b[$]);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    foreach (b[i]) begin
      c = c ^ {24'h0, b[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
    end
    return ~c;
  endfunction
  // mode 0 good crc, 1 skip sentinel, 2 corrupted crc
  task automatic boot(input int n, input int mode, input logic sec);
    logic [7:0] b[$];
    logic [31:0] w;
    logic [31:0] crcw;
    int cyc;
    exp_q.delete();
    got_q.delete();
    adr_q.delete();
    w = 32'(n);
    for (int i = 0; i < 4; i++) b.push_back(w[8*i+:8]);
    for (int j = 0; j < n; j++) begin
      w = $urandom();
      exp_q.push_back(w);
      for (int i = 0; i < 4; i++) b.push_back(w[8*i+:8]);
    end
    w = crc_of(b);
    if (mode == 1) w = 32'h0D15AB1E;
    if (mode == 2) w = ~w;
    for (int i = 0; i < 4; i++) b.push_back(w[8*i+:8]);
    crcw = w;
    foreach (b[k]) bil_flash_model_i.img_q.push_back(b[k]);
    w = $urandom();
    w[5] = sec;
    security_reg <= w;
    rst_pin_n <= 1'b0;
    repeat (6) tick();
    check("pull_down", 32'h1, 32'(gpio_pull_down));
    check("exec_in_rst", 32'h0, 32'(exec_start));
    rst_pin_n <= 1'b1;
    cyc = 0;
    while (src_start !== 1'b1 && cyc < 2000) begin
      tick();
      cyc++;
    end
    check("seq_delay", 32'h1, 32'(cyc >= 150 && cyc <= 1500));
    check("src_sel", sec ? 32'(bil_pkg::BIL_SRC_OTP) : 32'(bil_pkg::BIL_SRC_FLASH), 32'(src_sel));
    check("src_addr", 32'h0, src_addr);
    cyc = 0;
    while (exec_start !== 1'b1 && boot_fail !== 1'b1 && cyc < 2000) begin
      tick();
      cyc++;
    end
    check("exec", 32'(mode != 2), 32'(exec_start));
    check("fail", 32'(mode == 2), 32'(boot_fail));
    check("exec_addr", 32'h0, exec_addr);
    check("pull_run", 32'h0, 32'(gpio_pull_down));
    check("words", 32'(exp_q.size()), 32'(got_q.size()));
    foreach (exp_q[k]) check("word", exp_q[k], got_q[k]);
    if (n > 0) check("ram_base", 32'h0, adr_q[0]);
    reg_rd(bil_pkg::REG_STATUS, rd);
    check("status", 32'(mode != 2) | (32'(mode == 2) << 1), rd & 32'h3);
    check("status_sec", 32'(sec), (rd >> 2) & 32'h1);
    reg_rd(bil_pkg::REG_LENGTH, rd);
    check("len_reg", 32'(n), rd);
    reg_rd(bil_pkg::REG_CRC, rd);
    check("crc_reg", crcw, rd);
  endtask
  initial begin
    repeat (40000) @(posedge clk_sys);
    mismatches++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'h77ED));
    repeat (4) tick();
    srst <= 1'b0;
    tick();
    check("pll_rst", {11'h000, 3'h1, 12'h03F, 6'h00}, 32'(pll_cfg));
    reg_rd(bil_pkg::REG_PLL_CFG, rd);
    check("pll_reg_rst", 32'h00103F00, rd);
    repeat (10000) tick();
    boot(2, 0, 1'b0);
    boot(3, 1, 1'b1);
    boot(1, 2, 1'b0);
    boot(0, 0, 1'b1);
    v = {9'h000, 3'($urandom_range(7)), 12'($urandom()), 2'b00, 6'($urandom_range(63))};
    reg_wr(bil_pkg::REG_PLL_CFG, v);
    check("pll_port", {11'h000, v[22:20], v[19:8], v[5:0]}, 32'(pll_cfg));
    reg_rd(bil_pkg::REG_PLL_CFG, rd);
    check("pll_reg", v, rd);
    reg_rd(4'h2, rd);
    check("unmapped", 32'h0, rd);
    give_verdict();
  end
endmodule
`default_nettype wire
